// *** inc/sub_exec_pkg.sv ***
package sub_exec_pkg;
   // register byte offsets on the apb side
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_ACC = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_BANK = 8'h0c;
   localparam logic [7:0] OFF_CTRL = 8'h10;
   localparam logic [7:0] OFF_INDEX = 8'h14;
   // status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   // control bit positions
   localparam int CT_EXT = 0;
   localparam int CT_BUSY = 1;
   localparam int CT_ILL = 2;
   // instruction encodings
   localparam logic [5:0] OPC_FILE = 6'h17;
   localparam logic [7:0] OPC_LIT = 8'h08;
   localparam int POS_DEST = 9;
   localparam int POS_BANKSEL = 8;
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   // values after reset
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [4:0] RST_STATUS = 5'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic [11:0] RST_INDEX = 12'h000;
   localparam logic [15:0] RST_INSTR = 16'h0000;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_Q1 = 3'b001,
      PH_Q2 = 3'b011,
      PH_Q3 = 3'b010,
      PH_Q4 = 3'b110
   } phase_t;
endpackage : sub_exec_pkg

// *** design/subtract_w_from_file_exec.sv ***
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE1: difference is file operand minus accumulator, no incoming borrow.
// RULE2: destination bit 0 writes accumulator, 1 writes the file register.
// RULE3: bank bit 0 uses access bank, 1 uses bank select register.
// RULE4: bank 0, extended set on, address up to 95 means indexed offset.
// RULE5: nonzero result without borrow sets carry, clears zero; negative taken from result bit 7.
// RULE6: zero result sets zero and carry, clears negative, both forms.
// RULE7: borrow clears carry and zero, negative taken from result bit 7, both forms.
// RULE8: borrow wraps modulo 256; negative equals stored bit 7.
// RULE9: file form decoded from top six bits 010111, then d, a, f.
// RULE10: one cycle of four phases: decode, read, subtract, write.
module subtract_w_from_file_exec #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // data memory
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata
);
   // the address split is hard-wired to four bank bits
   if (ADDR_W != 12) begin : g_addr_w_check
      $error("ADDR_W must be 12: four bank bits over an 8-bit offset");
   end

   typedef struct packed {
      sub_exec_pkg::phase_t ph;
      logic [15:0] instr;
      logic [7:0] acc;
      logic [4:0] status;
      logic [3:0] bank;
      logic [11:0] index;
      logic ext_en;
      logic illegal;
      logic lit;
      logic dest_file;
      logic [7:0] res;
      logic [4:0] flg;
      logic [11:0] addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;

   state_t s_q, s_d;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == sub_exec_pkg::OFF_INSTR) || (a == sub_exec_pkg::OFF_ACC)
         || (a == sub_exec_pkg::OFF_STATUS) || (a == sub_exec_pkg::OFF_BANK)
         || (a == sub_exec_pkg::OFF_CTRL) || (a == sub_exec_pkg::OFF_INDEX);
   endfunction : reg_hit

   function automatic logic [11:0] eff_addr(input logic [15:0] ins,
         input logic [3:0] bank_select_reg, input logic [11:0] idx, input logic ext);
      logic [7:0] f;
      f = ins[7:0];
      if (ins[sub_exec_pkg::POS_BANKSEL]) begin
         eff_addr = {bank_select_reg, f}; // RULE3
      end else if (ext && f <= sub_exec_pkg::IDX_LIMIT) begin
         // indexed offset wraps within the 12-bit space
         eff_addr = idx + {4'h0, f}; // RULE4
      end else if (f >= sub_exec_pkg::ACCESS_SPLIT) begin
         eff_addr = {sub_exec_pkg::ACCESS_HI_BANK, f}; // RULE3
      end else begin
         eff_addr = {4'h0, f};
      end
   endfunction : eff_addr

   logic busy;
   logic [7:0] op_a;
   logic [8:0] diff;
   logic [4:0] nib;
   logic [4:0] flg;
   logic [31:0] rd_val;
   logic refuse;
   logic fault;

   always_comb begin
      busy = (s_q.ph != sub_exec_pkg::PH_IDLE);
      op_a = s_q.lit ? s_q.instr[7:0] : mem_rdata;
      diff = {1'b0, op_a} - {1'b0, s_q.acc}; // RULE1
      nib = {1'b0, op_a[3:0]} - {1'b0, s_q.acc[3:0]};
      flg = '0;
      flg[sub_exec_pkg::ST_C] = ~diff[8]; // RULE5 RULE6 RULE7
      flg[sub_exec_pkg::ST_DC] = ~nib[4];
      flg[sub_exec_pkg::ST_Z] = (diff[7:0] == 8'h00); // RULE6
      flg[sub_exec_pkg::ST_OV] = (op_a[7] ^ s_q.acc[7])
         & (op_a[7] ^ diff[7]);
      flg[sub_exec_pkg::ST_N] = diff[7]; // RULE8
      rd_val = '0;
      unique case (paddr)
         sub_exec_pkg::OFF_INSTR: rd_val[15:0] = s_q.instr;
         sub_exec_pkg::OFF_ACC: rd_val[7:0] = s_q.acc;
         sub_exec_pkg::OFF_STATUS: rd_val[4:0] = s_q.status;
         sub_exec_pkg::OFF_BANK: rd_val[3:0] = s_q.bank;
         sub_exec_pkg::OFF_CTRL: begin
            rd_val[sub_exec_pkg::CT_EXT] = s_q.ext_en;
            rd_val[sub_exec_pkg::CT_BUSY] = busy;
            rd_val[sub_exec_pkg::CT_ILL] = s_q.illegal;
         end
         sub_exec_pkg::OFF_INDEX: rd_val[11:0] = s_q.index;
         default: rd_val = '0;
      endcase
      // software may not write the instruction, accumulator, status or bank while an instruction runs
      refuse = !reg_hit(paddr) || (pwrite && busy
         && paddr != sub_exec_pkg::OFF_CTRL
         && paddr != sub_exec_pkg::OFF_INDEX);
      // decode fault raised this cycle, so a software clear must lose
      fault = (s_q.ph == sub_exec_pkg::PH_Q1)
         && s_q.instr[15:10] != sub_exec_pkg::OPC_FILE
         && s_q.instr[15:8] != sub_exec_pkg::OPC_LIT;
   end

   always_comb begin
      s_d = s_q;
      s_d.mem_rd = 1'b0;
      s_d.mem_wr = 1'b0;
      // answer one cycle into the access phase, release after it
      if (psel && penable && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.pslverr = refuse;
         s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
      unique case (s_q.ph)
         sub_exec_pkg::PH_IDLE: ;
         sub_exec_pkg::PH_Q1: begin
            s_d.dest_file = s_q.instr[sub_exec_pkg::POS_DEST];
            // address held from here until the next instruction
            s_d.addr = eff_addr(s_q.instr, s_q.bank, s_q.index, s_q.ext_en);
            if (s_q.instr[15:10] == sub_exec_pkg::OPC_FILE) begin // RULE9
               s_d.lit = 1'b0;
               s_d.mem_rd = 1'b1;
               s_d.ph = sub_exec_pkg::PH_Q2; // RULE10
            end else if (s_q.instr[15:8] == sub_exec_pkg::OPC_LIT) begin
               s_d.lit = 1'b1;
               s_d.dest_file = 1'b0;
               s_d.ph = sub_exec_pkg::PH_Q2;
            end else begin
               s_d.illegal = 1'b1;
               s_d.ph = sub_exec_pkg::PH_IDLE;
            end
         end
         sub_exec_pkg::PH_Q2: s_d.ph = sub_exec_pkg::PH_Q3; // RULE10
         sub_exec_pkg::PH_Q3: begin
            s_d.res = diff[7:0]; // RULE8
            s_d.flg = flg;
            s_d.mem_wdata = diff[7:0];
            s_d.mem_wr = s_q.dest_file; // RULE2
            s_d.ph = sub_exec_pkg::PH_Q4; // RULE10
         end
         sub_exec_pkg::PH_Q4: begin
            if (!s_q.dest_file) begin
               s_d.acc = s_q.res; // RULE2
            end
            s_d.status = s_q.flg; // RULE5 RULE6 RULE7
            s_d.ph = sub_exec_pkg::PH_IDLE;
         end
      endcase
      // write commits at the edge where pready is seen high
      if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
         unique case (paddr)
            sub_exec_pkg::OFF_INSTR: begin
               s_d.instr = pwdata[15:0];
               s_d.ph = sub_exec_pkg::PH_Q1;
            end
            sub_exec_pkg::OFF_ACC: s_d.acc = pwdata[7:0];
            sub_exec_pkg::OFF_STATUS: s_d.status = pwdata[4:0];
            sub_exec_pkg::OFF_BANK: s_d.bank = pwdata[3:0];
            sub_exec_pkg::OFF_CTRL: begin
               s_d.ext_en = pwdata[sub_exec_pkg::CT_EXT];
               // clear by writing one; a fresh decode fault wins
               if (pwdata[sub_exec_pkg::CT_ILL] && !fault) begin
                  s_d.illegal = 1'b0;
               end
            end
            sub_exec_pkg::OFF_INDEX: s_d.index = pwdata[11:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{ph: sub_exec_pkg::PH_IDLE,
            instr: sub_exec_pkg::RST_INSTR, acc: sub_exec_pkg::RST_ACC,
            status: sub_exec_pkg::RST_STATUS, bank: sub_exec_pkg::RST_BANK,
            index: sub_exec_pkg::RST_INDEX, default: '0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign mem_addr = s_q.addr;
   assign mem_rd = s_q.mem_rd;
   assign mem_wr = s_q.mem_wr;
   assign mem_wdata = s_q.mem_wdata;
endmodule : subtract_w_from_file_exec

// *** verif/sub_exec_props.sv ***
`timescale 1ns/1ps
module sub_exec_props #(
   parameter int ADDR_W = 12
) (
   // apb side
   input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready, pslverr,
   // data memory side
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_rd, mem_wr
);
   logic [15:0] instr_q;
   logic go;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !clk_en);
   // only accepted instruction writes start execution
   assign go = clk_en && psel && penable && pready && pwrite
      && paddr == 8'h00 && !pslverr;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) instr_q <= 16'h0000;
      else if (go) instr_q <= pwdata[15:0];
   property p_rd_pulse; mem_rd |=> !mem_rd; endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read pulse long");
   property p_wr_gap; mem_wr |-> $past(mem_rd, 2); endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("write phase off");
   property p_wr_dest; mem_wr |-> instr_q[9]; endproperty
   a_wr_dest: assert property (p_wr_dest)
      else $error("write with d=0");
   property p_rd_addr;
      mem_rd && instr_q[8] |-> mem_addr[7:0] == instr_q[7:0];
   endproperty
   a_rd_addr: assert property (p_rd_addr)
      else $error("bank address");
   property p_hold; mem_rd |=> $stable(mem_addr) [*2]; endproperty
   a_hold: assert property (p_hold)
      else $error("address moved");
   property p_go; go && pwdata[15:10] == 6'h17 |-> ##2 mem_rd; endproperty
   a_go: assert property (p_go)
      else $error("no operand read");
   property p_lit;
      go && pwdata[15:8] == 8'h08 |=> (!mem_rd && !mem_wr) [*5];
   endproperty
   a_lit: assert property (p_lit)
      else $error("literal touched memory");
   property p_rdy; pready |=> !pready; endproperty
   a_rdy: assert property (p_rdy)
      else $error("pready long");
   cover property (mem_wr);
   cover property (mem_rd && !instr_q[8]);
   cover property (pready && pslverr);
endmodule : sub_exec_props
bind subtract_w_from_file_exec sub_exec_props #(.ADDR_W(ADDR_W))
   i_sub_exec_props (
   .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr);

// *** verif/subtract_w_from_file_exec_tb.sv ***
`timescale 1ns/1ps
module subtract_w_from_file_exec_tb;
   logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0;
   logic penable = 1'h0, pwrite = 1'h0, pready, pslverr, mem_rd, mem_wr;
   logic [7:0] paddr = '0, mem_rdata = '0, mem_wdata, opnd = '0, wd = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [11:0] mem_addr, ra = '0;
   int bad_count = 0, total_checks = 0, wn = 0;
   subtract_w_from_file_exec #(.ADDR_W(12)) i_subtract_w_from_file_exec (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_rdata, .mem_wr,
      .mem_wdata);
   initial forever #5 pclk = ~pclk;
   // memory toggles when not read, so stale data never passes
   always @(posedge pclk) begin
      mem_rdata <= mem_rd ? opnd : ~mem_rdata;
      if (mem_rd) ra <= mem_addr;
      if (mem_wr) wd <= mem_wdata;
      if (mem_wr) wn <= wn + 1;
   end
   task automatic chk(input logic [31:0] g, x);
      total_checks++;
      if (g !== x) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
         bad_count++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task automatic op(input logic [15:0] ins, input logic [7:0] w, f,
      input logic [11:0] ea);
      logic [7:0] df;
      logic [4:0] st;
      logic [31:0] r;
      logic e;
      int n;
      df = f - w;
      st = {df[7], f[7] != w[7] && df[7] != f[7], df == 8'h00,
         f[3:0] >= w[3:0], f >= w};
      n = wn;
      opnd <= f;
      apb(1'h1, 8'h04, {24'h0, w}, r, e);
      apb(1'h1, 8'h00, {16'h0, ins}, r, e);
      r = '1;
      for (int i = 0; i < 9 && r[1]; i++) apb(1'h0, 8'h10, '0, r, e);
      chk(r[1], 1'h0);
      apb(1'h0, 8'h04, '0, r, e);
      chk(r, ins[9] ? w : df);
      apb(1'h0, 8'h08, '0, r, e);
      chk(r, st);
      chk(wn - n, ins[9]);
      if (ins[9]) chk(wd, df);
      if (ins[15:10] == 6'h17) chk(ra, ea);
   endtask : op
   task automatic t_file;
      logic [31:0] r;
      logic e;
      apb(1'h1, 8'h0c, 32'h3, r, e);
      op({6'h17, 2'h3, 8'h20}, 8'h02, 8'h03, 12'h320);
      op({6'h17, 2'h1, 8'h21}, 8'h02, 8'h02, 12'h321);
      op({6'h17, 2'h3, 8'h22}, 8'h02, 8'h01, 12'h322);
      $display("test file done");
   endtask : t_file
   task automatic t_lit;
      op(16'h0802, 8'h01, 8'h02, '0);
      op(16'h0802, 8'h02, 8'h02, '0);
      op(16'h0802, 8'h03, 8'h02, '0);
      $display("test literal done");
   endtask : t_lit
   task automatic t_bank;
      logic [31:0] r;
      logic e;
      op({6'h17, 2'h2, 8'h80}, 8'h01, 8'h05, 12'hf80);
      op({6'h17, 2'h0, 8'h10}, 8'h01, 8'h05, 12'h010);
      apb(1'h1, 8'h14, 32'h100, r, e);
      apb(1'h1, 8'h10, 32'h1, r, e);
      op({6'h17, 2'h2, 8'h5f}, 8'h01, 8'h05, 12'h15f);
      op({6'h17, 2'h2, 8'h60}, 8'h01, 8'h05, 12'hf60);
      apb(1'h0, 8'h18, '0, r, e);
      chk(e, 1'h1);
      $display("test bank done");
   endtask : t_bank
   task automatic t_fault;
      logic [31:0] r;
      logic e;
      opnd <= 8'h05;
      apb(1'h1, 8'h04, 32'h1, r, e);
      apb(1'h1, 8'h00, {16'h0, 6'h17, 2'h0, 8'h10}, r, e);
      // lands while the instruction runs, so it must be refused
      apb(1'h1, 8'h04, 32'h77, r, e);
      chk(e, 1'h1);
      r = '1;
      for (int i = 0; i < 9 && r[1]; i++) apb(1'h0, 8'h10, '0, r, e);
      apb(1'h0, 8'h04, '0, r, e);
      chk(r, 32'h4);
      apb(1'h1, 8'h00, 32'hffff, r, e);
      apb(1'h0, 8'h10, '0, r, e);
      chk(r, 32'h5);
      apb(1'h1, 8'h10, 32'h5, r, e);
      apb(1'h0, 8'h10, '0, r, e);
      chk(r, 32'h1);
      apb(1'h0, 8'h04, '0, r, e);
      chk(r, 32'h4);
      $display("test fault done");
   endtask : t_fault
   task automatic t_hold;
      logic [31:0] r;
      logic e;
      int n;
      n = wn;
      opnd <= 8'h09;
      apb(1'h1, 8'h04, 32'h4, r, e);
      apb(1'h1, 8'h00, {16'h0, 6'h17, 2'h3, 8'h30}, r, e);
      clk_en <= 1'h0;
      repeat (5) @(posedge pclk);
      chk(wn - n, 0);
      clk_en <= 1'h1;
      r = '1;
      for (int i = 0; i < 9 && r[1]; i++) apb(1'h0, 8'h10, '0, r, e);
      chk(wn - n, 1);
      chk(wd, 8'h05);
      chk(ra, 12'h330);
      $display("test hold done");
   endtask : t_hold
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_file();
      t_lit();
      t_bank();
      t_fault();
      t_hold();
      end_sim();
   end
   initial begin
      #100us;
      bad_count++;
      end_sim();
   end
endmodule : subtract_w_from_file_exec_tb
